// ===== hw/rtci_pkg.sv
package rtci_pkg;
   // Clock rate and timing
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned XTAL_HZ = 32768;
   // Edge event length in microseconds, longest time rounds down
   localparam int unsigned EVT_US = 7900;
   localparam int unsigned EVT_CYC = (CLK_HZ / 1000) * EVT_US / 1000;
   // Carry deferral during a data read, microseconds
   localparam int unsigned DEFER_US = 500000;
   localparam int unsigned DEFER_CYC = (CLK_HZ / 1000) * (DEFER_US / 1000);
   // Correction interval in seconds per interval select
   localparam logic [5:0] CORR_INT_FINE = 6'h3C;
   localparam logic [5:0] CORR_INT_COARSE = 6'h14;
   localparam logic [5:0] SEC_PER_MIN = 6'h3C;
   // Correction register layout
   localparam int unsigned CORR_SEL_BIT = 0;
   localparam logic [7:0] CORR_RESET = 8'h00;
   localparam logic [6:0] CORR_ZERO = 7'h00;
   localparam logic [6:0] CORR_SIGN = 7'h40;
   // Frequency select field: one bit per tap of the divider
   localparam int unsigned FSEL_W = 5;
   localparam logic [7:0] FREQ_RESET = 8'h00;
   // Power-on frequency select gives the 1 Hz tap
   localparam logic [7:0] FREQ_POR = 8'h80;
   // Output mode select encoding
   typedef enum logic [2:0] {
      RTCI_MODE_OFF = 3'b000,
      RTCI_MODE_FREQ = 3'b001,
      RTCI_MODE_EDGE = 3'b010,
      RTCI_MODE_PER1 = 3'b011,
      RTCI_MODE_PER2 = 3'b100,
      RTCI_MODE_XTAL = 3'b101
   } rtci_mode_t;
   // Host command port offsets
   localparam logic [3:0] ADR_MODE = 4'h0;
   localparam logic [3:0] ADR_FREQ = 4'h1;
   localparam logic [3:0] ADR_CORR = 4'h2;
   localparam logic [3:0] ADR_STAT = 4'h3;
   localparam logic [3:0] ADR_PIN = 4'h4;
endpackage

// ===== hw/rtci_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtci_if;
   import rtci_pkg::*;
   // Open-drain interrupt line, driven low when enabled
   logic int_out_en;
   logic int_level;
   // Configuration fields the host writes into the device
   rtci_mode_t mode;
   logic [7:0] freq_sel;
   logic [7:0] corr;
   logic init;
   logic rt_read;
   logic rt_write;
   logic [5:0] rt_sec;
   // Device status back to host
   logic power_on_flag;
   assign int_level = ~int_out_en;
   modport dev (input mode, freq_sel, corr, init, rt_read, rt_write,
      rt_sec, output int_out_en, power_on_flag);
   modport host (output mode, freq_sel, corr, init, rt_read, rt_write,
      rt_sec, input int_level, power_on_flag);
endinterface
`default_nettype wire

// ===== hw/rtci_dev.sv
`timescale 1ns/1ns
`default_nettype none
module rtci_dev
   import rtci_pkg::*;
#(
   parameter int unsigned DIV_HZ = XTAL_HZ,
   parameter int unsigned EVT_LEN = EVT_CYC,
   parameter int unsigned DEFER_LEN = DEFER_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Link to host
   rtci_if.dev link,
   // Divider taps for monitoring
   output logic sec_tick_o,
   output logic min_carry_o
);
   // Crystal tick prescaler from system clock
   // A scaled-down divider ticks every clock to keep short runs short
   localparam int unsigned PRE = (DIV_HZ < XTAL_HZ) ? 1 : CLK_HZ / DIV_HZ;
   localparam int unsigned DW = $clog2(DIV_HZ);
   logic [15:0] pre_reg;
   logic xt_tick;
   assign xt_tick = (pre_reg == 16'(PRE - 1));
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || xt_tick) pre_reg <= 16'h0000;
      else pre_reg <= pre_reg + 16'h0001;
   end

   // Correction: signed count from reversed field
   logic [6:0] corr_code;
   logic fine_sel;
   genvar gi;
   for (gi = 0; gi < 7; gi++) begin : g_rev
      assign corr_code[gi] = link.corr[7 - gi];
   end
   assign fine_sel = link.corr[CORR_SEL_BIT];
   // Code of 64 or more means extra counts, below 64 means fewer counts
   logic signed [7:0] corr_adj;
   assign corr_adj = (corr_code >= CORR_SIGN) ?
      $signed({1'b0, corr_code}) - $signed(8'h80) :
      $signed({1'b0, corr_code});

   // Divider chain from crystal ticks; one spare bit for long seconds
   logic [15:0] div_reg;
   logic [5:0] sec_reg;
   logic [5:0] corr_int;
   logic corr_now;
   logic [15:0] div_top;
   // Only the last second of each interval is stretched or shortened
   assign corr_int = fine_sel ? CORR_INT_FINE : CORR_INT_COARSE;
   assign corr_now = ((sec_reg % corr_int) ==
      (corr_int - 6'h01));
   // Two ticks per step; fine mode spreads it over 60 s
   assign div_top = corr_now ?
      16'($signed(32'(DIV_HZ - 1)) - 32'(corr_adj <<< 1)) :
      16'(DIV_HZ - 1);
   logic sec_wrap;
   assign sec_wrap = xt_tick && (div_reg >= div_top);
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || link.init) div_reg <= 16'h0000;
      else if (sec_wrap) div_reg <= 16'h0000;
      else if (xt_tick) div_reg <= div_reg + 16'h0001;
   end

   // Seconds; a data write loads seconds and shifts the carry
   logic carry_due;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || link.init) sec_reg <= 6'h00;
      else if (link.rt_write) sec_reg <= (link.rt_sec >= SEC_PER_MIN) ?
         6'h00 : link.rt_sec;
      else if (sec_wrap) sec_reg <= (sec_reg == SEC_PER_MIN - 6'h01) ?
         6'h00 : sec_reg + 6'h01;
   end
   assign carry_due = sec_wrap && (sec_reg == SEC_PER_MIN - 6'h01);

   // Carry held back while a data read runs, bounded
   logic pend_reg;
   logic [23:0] defer_reg;
   logic carry;
   assign carry = (pend_reg || carry_due) &&
      (!link.rt_read || defer_reg >= 24'(DEFER_LEN - 1));
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) pend_reg <= 1'b0;
      else pend_reg <= (pend_reg || carry_due) && !carry;
      if (srst_i || !(pend_reg || carry_due)) defer_reg <= 24'h000000;
      else defer_reg <= defer_reg + 24'h000001;
   end

   // Minute event window and periodic toggle
   logic [17:0] evt_reg;
   logic evt_live;
   logic half_reg;
   assign evt_live = (evt_reg != 18'h00000);
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || carry) evt_reg <= carry ? 18'(EVT_LEN) : 18'h00000;
      else if (evt_live) evt_reg <= evt_reg - 18'h00001;
   end

   // Mode tracking: wait for first carry after selection
   logic armed_reg;
   rtci_mode_t mode_last;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) mode_last <= RTCI_MODE_OFF;
      else mode_last <= link.mode;
      if (srst_i || link.mode != mode_last) armed_reg <= 1'b0;
      else if (carry) armed_reg <= 1'b1;
   end
   // 30 s half period of the minute square wave
   always_ff @(posedge clk_sys_i) begin
      // Phase runs free so a re-enable finds the low half
      if (srst_i) half_reg <= 1'b0;
      else if (carry) half_reg <= 1'b1;
      else if (sec_wrap && sec_reg == (SEC_PER_MIN >> 1) - 6'h01)
         half_reg <= 1'b0;
   end
   // Edge latch: low until enable cleared
   logic edge_reg;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || link.mode != RTCI_MODE_EDGE) edge_reg <= 1'b0;
      else if (!armed_reg && (carry || evt_live)) edge_reg <= 1'b1;
   end
   // Periodic 1 low phase remembered across a disable
   logic keep_reg;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !half_reg) keep_reg <= 1'b0;
      else if (link.mode == RTCI_MODE_PER1 && armed_reg) keep_reg <= 1'b1;
   end

   // Power-on flag and its frequency select
   logic por_reg;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) por_reg <= 1'b1;
      else if (link.init) por_reg <= 1'b0;
   end

   // Frequency taps: each of select bits 7 to 3 picks a divider stage; bits 2 to 0 are unused
   logic [7:0] fsel;
   logic [FSEL_W-1:0] tap_hit;
   assign fsel = por_reg ? FREQ_POR : link.freq_sel;
   for (gi = 0; gi < FSEL_W; gi++) begin : g_tap
      // Bit 7 is 1 Hz, each lower bit doubles the rate
      assign tap_hit[gi] = !fsel[7 - gi] || div_reg[DW - 1 - gi];
   end
   logic freq_wave;
   assign freq_wave = &tap_hit && (fsel[7:3] != 5'h00);

   // Pin low request per mode
   logic low_next;
   always_comb begin
      low_next = 1'b0;
      if (por_reg) begin
         low_next = freq_wave;
      end else begin
         unique case (link.mode)
            RTCI_MODE_OFF: low_next = 1'b0;
            RTCI_MODE_FREQ: low_next = freq_wave;
            // Re-enabling inside the window drives low again
            RTCI_MODE_EDGE: low_next = edge_reg;
            RTCI_MODE_PER1: low_next = half_reg &&
               (armed_reg || keep_reg);
            RTCI_MODE_PER2: low_next = armed_reg && evt_live;
            RTCI_MODE_XTAL: low_next = div_reg[0];
            default: low_next = 1'b0;
         endcase
      end
   end

   // Registered pin and flags
   logic low_reg;
   logic tick_reg;
   logic mc_reg;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         low_reg <= 1'b0;
         tick_reg <= 1'b0;
         mc_reg <= 1'b0;
      end else begin
         low_reg <= low_next;
         tick_reg <= sec_wrap;
         mc_reg <= carry;
      end
   end
   assign link.int_out_en = low_reg;
   assign link.power_on_flag = por_reg;
   assign sec_tick_o = tick_reg;
   assign min_carry_o = mc_reg;
endmodule
`default_nettype wire

// ===== hw/rtci_host.sv
`timescale 1ns/1ns
`default_nettype none
module rtci_host
   import rtci_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Software command port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Real-time access strobes from software
   input wire logic rt_read_i,
   input wire logic rt_write_i,
   input wire logic [5:0] rt_sec_i,
   input wire logic init_i,
   // Link to device
   rtci_if.host link
);
   // Decode
   wire wr_mode = wr_i && addr_i == ADR_MODE;
   wire wr_freq = wr_i && addr_i == ADR_FREQ;
   wire wr_corr = wr_i && addr_i == ADR_CORR;
   rtci_mode_t mode_reg;
   logic [7:0] freq_reg;
   logic [7:0] corr_reg;
   logic init_reg;
   logic rtr_reg;
   logic rtw_reg;
   logic [5:0] sec_reg;
   logic [7:0] rdata_reg;
   // Mode write selects pin behaviour edge mode implies
   // crystal and frequency outputs off by encoding
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mode_reg <= RTCI_MODE_OFF;
         freq_reg <= FREQ_RESET;
         corr_reg <= CORR_RESET;
      end else begin
         if (wr_mode) mode_reg <= rtci_mode_t'(wdata_i[2:0]);
         if (wr_freq) freq_reg <= wdata_i;
         // Software supplies 128-n or n+1, reversed
         if (wr_corr) corr_reg <= wdata_i;
      end
   end
   // Strobes passed on registered
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         init_reg <= 1'b0;
         rtr_reg <= 1'b0;
         rtw_reg <= 1'b0;
         sec_reg <= 6'h00;
      end else begin
         init_reg <= init_i;
         rtr_reg <= rt_read_i;
         rtw_reg <= rt_write_i;
         sec_reg <= rt_sec_i;
      end
   end
   // Read mux, unmapped reads zero
   logic [7:0] rd_mux;
   assign rd_mux = (addr_i == ADR_MODE) ? {5'h00, mode_reg} :
      (addr_i == ADR_FREQ) ? freq_reg :
      (addr_i == ADR_CORR) ? corr_reg :
      (addr_i == ADR_STAT) ? {7'h00, link.power_on_flag} :
      (addr_i == ADR_PIN) ? {7'h00, link.int_level} : 8'h00;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) rdata_reg <= 8'h00;
      else if (rd_i) rdata_reg <= rd_mux;
      else rdata_reg <= 8'h00;
   end
   assign rdata_o = rdata_reg;
   assign link.mode = mode_reg;
   assign link.freq_sel = freq_reg;
   assign link.corr = corr_reg;
   assign link.init = init_reg;
   assign link.rt_read = rtr_reg;
   assign link.rt_write = rtw_reg;
   assign link.rt_sec = sec_reg;
endmodule
`default_nettype wire

// ===== dv/rtci_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rtci_properties
   import rtci_pkg::*;
#(
   parameter int unsigned DIV_HZ = 128,
   parameter int unsigned EVT_LEN = 40
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Link and divider taps
   input wire logic int_out_en,
   input wire rtci_mode_t mode,
   input wire logic init,
   input wire logic power_on_flag,
   input wire logic sec_tick_o,
   input wire logic min_carry_o
);
   logic [31:0] low_cnt_reg;
   logic [31:0] hold_cnt_reg;
   logic [7:0] sec_cnt_reg;
   logic seen_reg;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // Run lengths; init clears the divider, so counts restart there
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || init) begin
         low_cnt_reg <= '0;
         hold_cnt_reg <= '0;
         sec_cnt_reg <= '0;
         seen_reg <= 1'b0;
      end else begin
         low_cnt_reg <= int_out_en ? low_cnt_reg + 1 : '0;
         hold_cnt_reg <= $changed(int_out_en) ? '0 : hold_cnt_reg + 1;
         sec_cnt_reg <= min_carry_o ? 8'h00 : sec_cnt_reg + 8'(sec_tick_o);
         seen_reg <= seen_reg | min_carry_o;
      end
   end
   a_off_released: assert property ((mode == RTCI_MODE_OFF &&
      !power_on_flag) [*2] |-> !int_out_en) else $error("pin held");
   a_edge_holds: assert property (mode == RTCI_MODE_EDGE && $stable(mode)
      && int_out_en |=> int_out_en) else $error("edge lost");
   a_per2_length: assert property ($fell(int_out_en) &&
      mode == RTCI_MODE_PER2 && $stable(mode) |-> low_cnt_reg >= EVT_LEN - 2
      && low_cnt_reg <= EVT_LEN + 2) else $error("pulse len");
   a_per1_start: assert property ($rose(int_out_en) &&
      mode == RTCI_MODE_PER1 && $past(mode, 2) == RTCI_MODE_PER1 |->
      $past(min_carry_o) || $past(min_carry_o, 2) || $past(min_carry_o, 3))
      else $error("start off carry");
   a_pon_set: assert property ($fell(srst_i) |-> power_on_flag)
      else $error("flag clear");
   a_pon_pulse: assert property (power_on_flag |->
      hold_cnt_reg <= 2 * DIV_HZ) else $error("no 1 Hz");
   a_init_clears: assert property (init |-> ##[1:3] !power_on_flag)
      else $error("flag kept");
   a_flag_sticky: assert property (!power_on_flag |=> !power_on_flag)
      else $error("flag set");
   a_minute_count: assert property (min_carry_o && seen_reg |->
      sec_cnt_reg >= 59 && sec_cnt_reg <= 61) else $error("min len");
   // Main scenarios reached
   c_edge: cover property (mode == RTCI_MODE_EDGE && $rose(int_out_en));
   c_per2: cover property (mode == RTCI_MODE_PER2 && $fell(int_out_en));
   c_per1: cover property (mode == RTCI_MODE_PER1 && $rose(int_out_en));
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import rtci_pkg::*;
   localparam int unsigned DIV = 128;
   localparam int unsigned EVT = 40;
   logic clk_sys_i, srst_i, wr, rd, init, carry, tick, lo, hi;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic rtr, rtw;
   logic [5:0] rts;
   int err_total, n_tests, a, k, nd, sh;
   rtci_if link();
   // Both ends face each other on one link
   rtci_dev #(.DIV_HZ(DIV), .EVT_LEN(EVT), .DEFER_LEN(50)) rtci_dev_inst (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link),
      .sec_tick_o(tick), .min_carry_o(carry));
   rtci_host rtci_host_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .rt_read_i(rtr), .rt_write_i(rtw),
      .rt_sec_i(rts), .init_i(init), .link(link));
   rtci_properties #(.DIV_HZ(DIV), .EVT_LEN(EVT)) rtci_properties_inst (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .int_out_en(link.int_out_en), .mode(link.mode), .init(link.init),
      .power_on_flag(link.power_on_flag), .sec_tick_o(tick),
      .min_carry_o(carry));
   // 50 ns clock
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] ad, input logic [7:0] m,
      input logic [7:0] e);
      @(posedge clk_sys_i);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 chk(rdata & m, e);
   endtask
   // Skip w cycles, then note which pin levels show in n cycles
   task automatic pin(input int w, input int n, input logic [7:0] e);
      repeat (w) @(negedge clk_sys_i);
      lo = 1'b0;
      hi = 1'b0;
      repeat (n) begin
         @(negedge clk_sys_i);
         lo |= !link.int_level;
         hi |= link.int_level;
      end
      chk({6'h00, lo, hi}, e);
   endtask
   // Wait n carries (m) or ticks; k ends as the last gap in cycles
   task automatic wait_ev(input bit m, input int n);
      repeat (n) begin
         k = 0;
         do begin
            @(negedge clk_sys_i);
            k++;
         end while (!(m ? carry : tick) && k < 8000);
      end
   endtask
   // Count seconds whose length departs from the plain one
   task automatic corr_run(input logic [7:0] c, input int n);
      wr_reg(ADR_CORR, c);
      rd_chk(ADR_CORR, 8'hFF, c);
      wait_ev(0, 2);
      nd = 0;
      sh = 0;
      repeat (n) begin
         wait_ev(0, 1);
         nd += int'(k != a);
         sh += int'(k < a);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // About nine model minutes of traffic, with margin
   initial begin
      repeat (98000) @(posedge clk_sys_i);
      err_total++;
      complete_run();
   end
   // Main sequence
   initial begin
      {srst_i, wr, rd, init, addr, wdata} = {4'h8, 12'h000};
      {err_total, n_tests} = '0;
      {rtr, rtw, rts} = 8'h00;
      repeat (16) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      rd_chk(ADR_STAT, 8'h01, 8'h01);
      pin(0, 2 * DIV, 8'h03);
      @(posedge clk_sys_i);
      init <= 1'b1;
      @(posedge clk_sys_i);
      init <= 1'b0;
      rd_chk(ADR_STAT, 8'h01, 8'h00);
      pin(4, 2 * DIV, 8'h01);
      wait_ev(0, 2);
      a = k;
      rd_chk(4'hF, 8'hFF, 8'h00);
      wr_reg(ADR_FREQ, 8'h80);
      wr_reg(ADR_MODE, 8'h01);
      rd_chk(ADR_MODE, 8'hFF, 8'h01);
      pin(4, 2 * DIV, 8'h03);
      wr_reg(ADR_FREQ, 8'h00);
      pin(4, 2 * DIV, 8'h01);
      wr_reg(ADR_MODE, 8'h02);
      wait_ev(1, 1);
      pin(3, 1, 8'h02);
      wr_reg(ADR_MODE, 8'h00);
      pin(3, 1, 8'h01);
      wr_reg(ADR_MODE, 8'h02);
      pin(3, 1, 8'h02);
      pin(0, 2 * DIV, 8'h02);
      wr_reg(ADR_MODE, 8'h00);
      pin(3, 1, 8'h01);
      wr_reg(ADR_MODE, 8'h04);
      wait_ev(1, 1);
      pin(3, 1, 8'h02);
      pin(EVT, 1, 8'h01);
      wait_ev(1, 1);
      pin(3, 1, 8'h02);
      wr_reg(ADR_MODE, 8'h03);
      wait_ev(1, 1);
      rd_chk(ADR_PIN, 8'h01, 8'h00);
      wait_ev(0, 27);
      pin(0, 1, 8'h02);
      wait_ev(0, 4);
      pin(3, 1, 8'h01);
      wait_ev(1, 1);
      wr_reg(ADR_MODE, 8'h00);
      pin(3, 1, 8'h01);
      wr_reg(ADR_MODE, 8'h03);
      pin(3, 1, 8'h02);
      wr_reg(ADR_MODE, 8'h00);
      corr_run(8'hFC, 40);
      chk(8'(nd), 8'h02);
      chk(8'(sh), 8'h02);
      corr_run(8'h02, 40);
      chk(8'(nd), 8'h02);
      chk(8'(sh), 8'h00);
      corr_run(8'hFD, 120);
      chk(8'(nd), 8'h02);
      corr_run(8'h00, 20);
      chk(8'(nd), 8'h00);
      // Seconds written to 58, carry then held by a data read
      @(posedge clk_sys_i);
      init <= 1'b1;
      @(posedge clk_sys_i);
      init <= 1'b0;
      {rts, rtw, rtr} <= {6'h3A, 2'b11};
      @(posedge clk_sys_i);
      rtw <= 1'b0;
      wait_ev(0, 2);
      wait_ev(1, 1);
      chk({7'h00, k >= 2 && k <= 50}, 8'h01);
      rtr <= 1'b0;
      complete_run();
   end
endmodule
`default_nettype wire
